// ==== verilog/fcsm_pkg.sv ====
// shared constants and types for the flash command host controller
package fcsm_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 30;
  localparam int T_ACC_NS = 90;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int T_POWERUP_NS = 50000;
  // least times round up
  localparam logic [15:0] WP_CYC = 16'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] WPH_CYC = 16'((T_WPH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] ACC_CYC = 16'((T_ACC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RP_CYC = 16'((T_RP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RH_CYC = 16'((T_RH_NS * CLK_MHZ + 999) / 1000);
  localparam int POWERUP_CYC_DEF = (T_POWERUP_NS * CLK_MHZ + 999) / 1000;
  // ****************************************
  // command codes and unlock cycles
  // ****************************************
  localparam logic [16:0] UNLOCK_ADDR1 = 17'h00555;
  localparam logic [16:0] UNLOCK_ADDR2 = 17'h002AA;
  localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam int DQ_TOGGLE_BIT = 6;
  localparam int DQ_LIMIT_BIT = 5;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_AUTOSEL = 4'h2, OP_PROGRAM = 4'h3,
    OP_BYP_ENTER = 4'h4, OP_BYP_EXIT = 4'h5, OP_CHIP_ERASE = 4'h6,
    OP_ABORT = 4'h7, OP_HW_RESET = 4'h8
  } fcsm_op_t;
  typedef enum logic [1:0] {
    K_WRITE = 2'h0, K_READ = 2'h1, K_POLL = 2'h2, K_END = 2'h3
  } fcsm_kind_t;
  typedef struct packed {
    fcsm_kind_t kind;
    logic [16:0] addr;
    logic [7:0] data;
  } fcsm_step_t;
  typedef struct packed {
    fcsm_op_t op;
    logic [16:0] addr;
    logic [7:0] data;
  } fcsm_req_t;
endpackage

// ==== verilog/fcsm_host.sv ====
// host controller that drives a byte-wide flash through its bus pins
// Notes on behaviour
// RULE1: no writes while power comes up
// RULE2: flash starts in read-array, no command needed
// RULE3: bad sequence returns flash to read-array
// RULE4: address on later fall, data on rise
// RULE5: finished algorithm returns to read-array
// RULE6: erase-suspend reads: status inside erasing sectors
// RULE7: reset command works at any address
// RULE8: reset aborts unfinished sequences, not running erase
// RULE9: reset ignored while programming runs
// RULE10: autoselect is left only by reset
// RULE11: timing-limit flag high means write reset
// RULE12: autoselect reads codes at low addresses
// RULE13: autoselect 02h read gives sector protection
// RULE14: program is four writes, then runs alone
// RULE15: commands ignored while programming runs
// RULE16: hardware reset ends program at once
// RULE17: programming only clears bits
// RULE18: two unlocks plus 20h enter bypass
// RULE19: bypass program is A0h then address/data
// RULE20: bypass exit is 90h then 00h
// RULE21: chip erase is six writes
// RULE22: commands ignored during erase, hw reset aborts
// RULE23: unlock and command codes from command table
`timescale 1ns/1ps
`default_nettype none
module fcsm_host #(
  parameter int POWERUP_CYC = fcsm_pkg::POWERUP_CYC_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // user request and answer
  input wire logic req_valid,
  input wire fcsm_pkg::fcsm_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_error,
  // flash pins
  output logic [16:0] fl_addr,
  output logic [7:0] fl_dq_out,
  output logic fl_dq_oe,
  input wire logic [7:0] fl_dq_in,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_reset_n
);
  typedef enum logic [3:0] {
    ST_POWERUP = 4'h0, ST_IDLE = 4'h1, ST_FETCH = 4'h2, ST_WSET = 4'h3,
    ST_WLO = 4'h4, ST_WHI = 4'h5, ST_READ = 4'h6, ST_POLL = 4'h7,
    ST_HWRST = 4'h8, ST_HWREC = 4'h9, ST_DONE = 4'hA
  } fcsm_state_t;

  fcsm_state_t state, next_state;
  fcsm_pkg::fcsm_op_t op, next_op;
  fcsm_pkg::fcsm_step_t cur, next_cur;
  logic [2:0] step, next_step;
  logic [15:0] cnt, next_cnt;
  logic [16:0] req_addr, next_req_addr;
  logic [7:0] req_data, next_req_data;
  logic [7:0] rdata, next_rdata;
  logic bypass, next_bypass;
  logic have_prev, next_have_prev;
  logic prev_dq6, next_prev_dq6;
  logic limit_seen, next_limit_seen;
  logic err, next_err;
  logic next_rsp_valid;

  // ****************************************
  // command sequence table
  // ****************************************
  function automatic fcsm_pkg::fcsm_step_t mk(input fcsm_pkg::fcsm_kind_t k,
                                              input logic [16:0] a, input logic [7:0] d);
    fcsm_pkg::fcsm_step_t s;
    s.kind = k;
    s.addr = a;
    s.data = d;
    return s;
  endfunction

  // unlock pair is shared by every full sequence
  // RULE23 codes from package table
  function automatic fcsm_pkg::fcsm_step_t unlock(input logic [2:0] i);
    return (i[0] == 1'b0) ? mk(fcsm_pkg::K_WRITE, fcsm_pkg::UNLOCK_ADDR1, fcsm_pkg::UNLOCK_DATA1)
                          : mk(fcsm_pkg::K_WRITE, fcsm_pkg::UNLOCK_ADDR2, fcsm_pkg::UNLOCK_DATA2);
  endfunction

  // set-up and command writes of the full sequences go to the first unlock address
  function automatic fcsm_pkg::fcsm_step_t cmd(input logic [7:0] d);
    return mk(fcsm_pkg::K_WRITE, fcsm_pkg::UNLOCK_ADDR1, d);
  endfunction

  function automatic fcsm_pkg::fcsm_step_t step_of(input fcsm_pkg::fcsm_op_t o,
      input logic [2:0] i, input logic byp, input logic [16:0] a, input logic [7:0] d);
    fcsm_pkg::fcsm_step_t e;
    fcsm_pkg::fcsm_step_t s;
    e = mk(fcsm_pkg::K_END, 17'h00000, 8'h00);
    s = e;
    case (o)
      fcsm_pkg::OP_READ: begin
        if (i == 3'h0) s = mk(fcsm_pkg::K_READ, a, 8'h00);
      end
      // RULE20 bypass exit pair
      fcsm_pkg::OP_RESET, fcsm_pkg::OP_BYP_EXIT: begin
        if (byp && i == 3'h0) s = mk(fcsm_pkg::K_WRITE, a, fcsm_pkg::CMD_AUTOSEL);
        else if (byp && i == 3'h1) s = mk(fcsm_pkg::K_WRITE, a, fcsm_pkg::CMD_BYP_EXIT2);
        // RULE7 reset at any address
        else if (!byp && o == fcsm_pkg::OP_RESET && i == 3'h0)
          s = mk(fcsm_pkg::K_WRITE, a, fcsm_pkg::CMD_RESET);
      end
      fcsm_pkg::OP_ABORT: begin
        if (i == 3'h0) s = mk(fcsm_pkg::K_WRITE, 17'h00000, fcsm_pkg::CMD_RESET);
      end
      // RULE12 unlock, 90h, one read, then RULE10 reset exit
      fcsm_pkg::OP_AUTOSEL: begin
        if (i < 3'h2) s = unlock(i);
        else if (i == 3'h2) s = cmd(fcsm_pkg::CMD_AUTOSEL);
        else if (i == 3'h3) s = mk(fcsm_pkg::K_READ, a, 8'h00);
        else if (i == 3'h4) s = mk(fcsm_pkg::K_WRITE, 17'h00000, fcsm_pkg::CMD_RESET);
      end
      // RULE14 four writes, RULE19 two in bypass
      fcsm_pkg::OP_PROGRAM: begin
        if (byp) begin
          if (i == 3'h0) s = mk(fcsm_pkg::K_WRITE, a, fcsm_pkg::CMD_PROGRAM);
          else if (i == 3'h1) s = mk(fcsm_pkg::K_WRITE, a, d);
          else if (i == 3'h2) s = mk(fcsm_pkg::K_POLL, a, 8'h00);
        end else begin
          if (i < 3'h2) s = unlock(i);
          else if (i == 3'h2) s = cmd(fcsm_pkg::CMD_PROGRAM);
          else if (i == 3'h3) s = mk(fcsm_pkg::K_WRITE, a, d);
          else if (i == 3'h4) s = mk(fcsm_pkg::K_POLL, a, 8'h00);
        end
      end
      // RULE18 bypass entry
      fcsm_pkg::OP_BYP_ENTER: begin
        if (i < 3'h2) s = unlock(i);
        else if (i == 3'h2) s = cmd(fcsm_pkg::CMD_BYPASS);
      end
      // RULE21 six writes then poll
      fcsm_pkg::OP_CHIP_ERASE: begin
        if (i < 3'h2) s = unlock(i);
        else if (i == 3'h2) s = cmd(fcsm_pkg::CMD_ERASE_SETUP);
        else if (i < 3'h5) s = unlock(i - 3'h1);
        else if (i == 3'h5) s = cmd(fcsm_pkg::CMD_CHIP_ERASE);
        else if (i == 3'h6) s = mk(fcsm_pkg::K_POLL, 17'h00000, 8'h00);
      end
      default: s = e;
    endcase
    return s;
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_op = op;
    next_cur = cur;
    next_step = step;
    next_cnt = cnt + 16'h0001;
    next_req_addr = req_addr;
    next_req_data = req_data;
    next_rdata = rdata;
    next_bypass = bypass;
    next_have_prev = have_prev;
    next_prev_dq6 = prev_dq6;
    next_limit_seen = limit_seen;
    next_err = err;
    next_rsp_valid = 1'b0;
    case (state)
      // RULE1 strobes stay idle until supply settles
      ST_POWERUP: begin
        if (cnt == 16'(POWERUP_CYC - 1)) next_state = ST_IDLE;
      end
      ST_IDLE: begin
        next_cnt = 16'h0000;
        if (req_valid) begin
          next_op = req.op;
          next_req_addr = req.addr;
          next_req_data = req.data;
          next_step = 3'h0;
          next_err = 1'b0;
          next_have_prev = 1'b0;
          next_limit_seen = 1'b0;
          // RULE20 autoselect, chip erase and bypass entry are refused in bypass
          if (bypass && (req.op == fcsm_pkg::OP_AUTOSEL || req.op == fcsm_pkg::OP_CHIP_ERASE ||
                         req.op == fcsm_pkg::OP_BYP_ENTER)) begin
            next_err = 1'b1;
            next_state = ST_DONE;
          end else if (req.op == fcsm_pkg::OP_HW_RESET) begin
            next_state = ST_HWRST;
          end else begin
            next_state = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        next_cnt = 16'h0000;
        next_cur = step_of(op, step, bypass, req_addr, req_data);
        case (next_cur.kind)
          fcsm_pkg::K_WRITE: next_state = ST_WSET;
          fcsm_pkg::K_READ: next_state = ST_READ;
          fcsm_pkg::K_POLL: next_state = ST_POLL;
          default: next_state = ST_DONE;
        endcase
      end
      ST_WSET: begin
        next_cnt = 16'h0000;
        next_state = ST_WLO;
      end
      // RULE4 address settles before the fall, data held past the rise
      ST_WLO: begin
        if (cnt == fcsm_pkg::WP_CYC - 16'h0001) begin
          next_cnt = 16'h0000;
          next_state = ST_WHI;
        end
      end
      ST_WHI: begin
        if (cnt == fcsm_pkg::WPH_CYC - 16'h0001) begin
          next_step = step + 3'h1;
          next_state = ST_FETCH;
        end
      end
      ST_READ: begin
        if (cnt == fcsm_pkg::ACC_CYC - 16'h0001) begin
          next_rdata = fl_dq_in;
          next_step = step + 3'h1;
          next_state = ST_FETCH;
        end
      end
      // RULE15 nothing is written while the algorithm runs; toggle polling
      ST_POLL: begin
        if (cnt == fcsm_pkg::ACC_CYC - 16'h0001) begin
          next_rdata = fl_dq_in;
          next_have_prev = 1'b1;
          next_prev_dq6 = fl_dq_in[fcsm_pkg::DQ_TOGGLE_BIT];
          next_state = ST_FETCH;
          if (have_prev && fl_dq_in[fcsm_pkg::DQ_TOGGLE_BIT] == prev_dq6) begin
            // RULE5 finished, flash is back in read-array
            next_have_prev = 1'b0;
            next_step = step + 3'h1;
          end else if (have_prev && limit_seen) begin
            // RULE11 still toggling after the limit flag: write reset
            next_err = 1'b1;
            next_op = fcsm_pkg::OP_ABORT;
            next_step = 3'h0;
          end else if (have_prev && fl_dq_in[fcsm_pkg::DQ_LIMIT_BIT]) begin
            next_limit_seen = 1'b1;
          end
        end
      end
      // RULE16 hardware reset aborts any running algorithm
      ST_HWRST: begin
        if (cnt == fcsm_pkg::RP_CYC - 16'h0001) begin
          next_cnt = 16'h0000;
          next_bypass = 1'b0;
          next_state = ST_HWREC;
        end
      end
      ST_HWREC: begin
        if (cnt == fcsm_pkg::RH_CYC - 16'h0001) next_state = ST_DONE;
      end
      ST_DONE: begin
        next_rsp_valid = 1'b1;
        if (!err && op == fcsm_pkg::OP_BYP_ENTER) next_bypass = 1'b1;
        if (op == fcsm_pkg::OP_RESET || op == fcsm_pkg::OP_BYP_EXIT) next_bypass = 1'b0;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      // RULE2 no command issued at start-up
      state <= ST_POWERUP;
      op <= fcsm_pkg::OP_READ;
      cur <= '0;
      step <= 3'h0;
      cnt <= 16'h0000;
      req_addr <= 17'h00000;
      req_data <= 8'h00;
      rdata <= 8'h00;
      bypass <= 1'b0;
      have_prev <= 1'b0;
      prev_dq6 <= 1'b0;
      limit_seen <= 1'b0;
      err <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      cur <= next_cur;
      step <= next_step;
      cnt <= next_cnt;
      req_addr <= next_req_addr;
      req_data <= next_req_data;
      rdata <= next_rdata;
      bypass <= next_bypass;
      have_prev <= next_have_prev;
      prev_dq6 <= next_prev_dq6;
      limit_seen <= next_limit_seen;
      err <= next_err;
      rsp_valid <= next_rsp_valid;
    end
  end

  // ****************************************
  // pins
  // ****************************************
  assign req_ready = (state == ST_IDLE);
  assign rsp_data = rdata;
  assign rsp_error = err;
  assign fl_addr = cur.addr;
  assign fl_dq_out = cur.data;
  assign fl_dq_oe = (state == ST_WSET) || (state == ST_WLO) || (state == ST_WHI);
  assign fl_ce_n = !(fl_dq_oe || state == ST_READ || state == ST_POLL);
  assign fl_oe_n = !(state == ST_READ || state == ST_POLL);
  assign fl_we_n = (state != ST_WLO);
  assign fl_reset_n = (state != ST_HWRST);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_reset_write;
    $fell(fl_we_n) && fl_dq_out == fcsm_pkg::CMD_RESET;
  endsequence
  sequence s_bypass_prog;
    req_valid && req_ready && bypass && req.op == fcsm_pkg::OP_PROGRAM;
  endsequence

  AST_POWERUP_QUIET: assert property (state == ST_POWERUP |-> fl_we_n && !req_ready) // RULE1
    else $error("strobe or request during power-up");
  AST_WE_OE_EXCL: assert property (!(!fl_we_n && !fl_oe_n)) // RULE1
    else $error("write and output strobes low together");
  AST_WE_WIDTH: assert property ($fell(fl_we_n) |-> !fl_we_n [*7] ##1 fl_we_n) // RULE4
    else $error("write pulse width wrong");
  AST_DATA_STABLE: assert property (!fl_we_n |-> // RULE4
      fl_dq_oe && !fl_ce_n ##1 $stable(fl_dq_out))
    else $error("data moved while write strobe low");
  AST_LIMIT_RESET: assert property ($rose(err) && op == fcsm_pkg::OP_ABORT |-> // RULE11
      ##[1:6] s_reset_write)
    else $error("no reset after timing-limit flag");
  AST_AUTOSEL_EXIT: assert property (state == ST_READ && op == fcsm_pkg::OP_AUTOSEL // RULE10
      && next_state == ST_FETCH |-> ##[1:6] s_reset_write)
    else $error("autoselect not left by reset");
  AST_BYPASS_PROG: assert property (s_bypass_prog |-> // RULE19
      ##[1:6] ($fell(fl_we_n) && fl_dq_out == fcsm_pkg::CMD_PROGRAM))
    else $error("bypass program does not start with A0h");
  AST_HWRST_WIDTH: assert property ($fell(fl_reset_n) |-> !fl_reset_n [*8]) // RULE16
    else $error("hardware reset pulse too short");
  AST_NO_WRITE_POLL: assert property (state == ST_POLL |-> fl_we_n && !fl_dq_oe) // RULE15
    else $error("write during running algorithm");
endmodule
`default_nettype wire

// ==== sim/fcsm_flash_model.sv ====
// behavioural byte-wide flash answering the host controller's bus cycles
`timescale 1ns/1ps
`default_nettype none
module fcsm_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hA5, // arbitrary value
  parameter logic [4:0] PROT_SECTOR = 5'h03
) (
  // bus pins
  input wire logic [16:0] addr,
  input wire logic [7:0] dq,
  output logic [7:0] dq_dev,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  // test controls
  input wire logic [3:0] busy_reads,
  input wire logic limit
);
  logic [7:0] mem [int];
  logic [7:0] q = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] pd = 8'h00;
  logic [16:0] la = '0;
  logic [2:0] step = 3'h0;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic asel = 1'b0;
  logic byp = 1'b0;
  int left = 0;
  wire rd = ~ce_n & ~oe_n & reset_n;
  wire wr = ~ce_n & ~we_n & oe_n & reset_n;
  // released lines show the inverse, never a stale copy
  assign dq_dev = rd ? q : ~last;
  always @(addr, rd, busy, asel, tog, limit, pd) begin
    if (busy) q = {~pd[7], tog, limit, 5'h00};
    else if (asel && addr[7:0] == 8'h00) q = MFR_CODE;
    else if (asel && addr[7:0] == 8'h01) q = DEV_CODE;
    else if (asel && addr[7:0] == 8'h02) q = {7'h00, addr[16:12] == PROT_SECTOR};
    else q = mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hFF;
  end
  always @(negedge rd) begin
    last = q;
    tog = ~tog;
    if (busy && !limit) begin
      left--;
      if (left <= 0) busy = 1'b0;
    end
  end
  always @(negedge reset_n) begin
    busy = 1'b0;
    step = 3'h0;
    asel = 1'b0;
    byp = 1'b0;
  end
  always @(posedge wr) la = addr;
  task automatic start_prog(input logic [7:0] d);
    mem[int'(la)] = (mem.exists(int'(la)) ? mem[int'(la)] : 8'hFF) & d;
    pd = d;
    busy = 1'b1;
    left = int'(busy_reads);
    step = 3'h0;
  endtask
  always @(negedge wr) begin
    if (busy) begin
      if (limit && dq == 8'hF0) busy = 1'b0;
    end else if (byp) begin
      if (step == 3'h1) start_prog(dq);
      else if (step == 3'h2) begin
        byp = dq != 8'h00;
        step = 3'h0;
      end else step = dq == 8'hA0 ? 3'h1 : dq == 8'h90 ? 3'h2 : 3'h0;
    end else if (dq == 8'hF0) begin
      asel = 1'b0;
      step = 3'h0;
    end else if (asel) begin
      step = 3'h0;
    end else if (step == 3'h3) start_prog(dq);
    else if (step == 3'h2 && la == 17'h00555) begin
      asel = dq == 8'h90;
      byp = dq == 8'h20;
      step = dq == 8'hA0 ? 3'h3 : dq == 8'h80 ? 3'h4 : 3'h0;
    end else if (step == 3'h6 && la == 17'h00555 && dq == 8'h10) begin
      mem.delete();
      pd = 8'hFF;
      busy = 1'b1;
      left = int'(busy_reads);
      step = 3'h0;
    end else if ((step == 3'h0 || step == 3'h4) && la == 17'h00555 && dq == 8'hAA) step++;
    else if ((step == 3'h1 || step == 3'h5) && la == 17'h002AA && dq == 8'h55) step++;
    else step = 3'h0;
  end
endmodule
`default_nettype wire

// ==== sim/flash_command_state_machine_tb.sv ====
// self-checking bench for the flash host controller against a flash model
`timescale 1ns/1ps
`default_nettype none
module flash_command_state_machine_tb;
  localparam logic [7:0] MFR = 8'h3C;
  localparam logic [7:0] DEV = 8'hA5;
  logic clock, nrst, req_valid, req_ready, rsp_valid, rsp_error, limit;
  fcsm_pkg::fcsm_req_t req;
  logic [7:0] rsp_data, fl_dq_out, dq_dev;
  logic [16:0] fl_addr;
  logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n;
  logic [3:0] busy_reads;
  int failures, checks_done;
  wire logic [7:0] dq_line = fl_dq_oe ? fl_dq_out : dq_dev;
  fcsm_host #(.POWERUP_CYC(4)) u_dut (.clock(clock), .nrst(nrst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
    .fl_dq_in(dq_line), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_reset_n(fl_reset_n));
  fcsm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .PROT_SECTOR(5'h03)) u_flash (
    .addr(fl_addr), .dq(dq_line), .dq_dev(dq_dev), .ce_n(fl_ce_n), .oe_n(fl_oe_n),
    .we_n(fl_we_n), .reset_n(fl_reset_n), .busy_reads(busy_reads), .limit(limit));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // called just after a falling edge; returns once the answer is seen
  task automatic run(input fcsm_pkg::fcsm_op_t op, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = '{op, a, d};
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    if (n >= 300) begin
      failures++;
      stop_test();
    end
    @(negedge clock);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      stop_test();
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic sc_powerup;
    repeat (2) @(negedge clock);
    check("ready_in_powerup", {7'h00, req_ready}, 8'h00);
    check("we_n_in_powerup", {7'h00, fl_we_n}, 8'h01);
    run(fcsm_pkg::OP_READ, 17'h01234, 8'h00);
    check("first_read", rsp_data, 8'hFF);
  endtask
  task automatic sc_program;
    busy_reads = 4'h1;
    run(fcsm_pkg::OP_PROGRAM, 17'h00100, 8'h5A);
    check("prog_error", {7'h00, rsp_error}, 8'h00);
    run(fcsm_pkg::OP_READ, 17'h00100, 8'h00);
    check("prog_read", rsp_data, 8'h5A);
    busy_reads = 4'h6;
    run(fcsm_pkg::OP_PROGRAM, 17'h00100, 8'hA5);
    run(fcsm_pkg::OP_READ, 17'h00100, 8'h00);
    check("clear_only", rsp_data, 8'h00);
  endtask
  task automatic sc_autosel;
    logic [16:0] ad [4] = '{17'h1AB00, 17'h0CD01, 17'h03002, 17'h05002};
    logic [7:0] ex [4] = '{MFR, DEV, 8'h01, 8'h00};
    for (int i = 0; i < 4; i++) begin
      run(fcsm_pkg::OP_AUTOSEL, ad[i], 8'h00);
      check("autosel_code", rsp_data, ex[i]);
    end
    run(fcsm_pkg::OP_READ, 17'h00100, 8'h00);
    check("after_autosel", rsp_data, 8'h00);
  endtask
  task automatic sc_bypass;
    busy_reads = 4'h2;
    run(fcsm_pkg::OP_BYP_ENTER, 17'h00000, 8'h00);
    run(fcsm_pkg::OP_PROGRAM, 17'h00200, 8'h11);
    run(fcsm_pkg::OP_PROGRAM, 17'h00201, 8'h22);
    run(fcsm_pkg::OP_AUTOSEL, 17'h00000, 8'h00);
    check("byp_refused", {7'h00, rsp_error}, 8'h01);
    run(fcsm_pkg::OP_CHIP_ERASE, 17'h00000, 8'h00);
    check("byp_refused_erase", {7'h00, rsp_error}, 8'h01);
    run(fcsm_pkg::OP_BYP_EXIT, 17'h1FFFF, 8'h00);
    run(fcsm_pkg::OP_AUTOSEL, 17'h00000, 8'h00);
    check("byp_left", rsp_data, MFR);
    run(fcsm_pkg::OP_READ, 17'h00200, 8'h00);
    check("byp_prog0", rsp_data, 8'h11);
    run(fcsm_pkg::OP_READ, 17'h00201, 8'h00);
    check("byp_prog1", rsp_data, 8'h22);
    run(fcsm_pkg::OP_BYP_ENTER, 17'h00000, 8'h00);
    run(fcsm_pkg::OP_BYP_ENTER, 17'h00000, 8'h00);
    check("byp_reenter_refused", {7'h00, rsp_error}, 8'h01);
    run(fcsm_pkg::OP_RESET, 17'h0ABCD, 8'h00);
    run(fcsm_pkg::OP_AUTOSEL, 17'h00001, 8'h00);
    check("byp_reset_left", rsp_data, DEV);
  endtask
  task automatic sc_limit_reset;
    limit = 1'b1;
    run(fcsm_pkg::OP_PROGRAM, 17'h00300, 8'h0F);
    check("limit_error", {7'h00, rsp_error}, 8'h01);
    limit = 1'b0;
    run(fcsm_pkg::OP_READ, 17'h00201, 8'h00);
    check("limit_exit", rsp_data, 8'h22);
    run(fcsm_pkg::OP_RESET, 17'h1ABCD, 8'h00);
    check("reset_error", {7'h00, rsp_error}, 8'h00);
    run(fcsm_pkg::OP_HW_RESET, 17'h00000, 8'h00);
    run(fcsm_pkg::OP_READ, 17'h00200, 8'h00);
    check("hw_reset_read", rsp_data, 8'h11);
  endtask
  task automatic sc_erase;
    busy_reads = 4'h8;
    run(fcsm_pkg::OP_CHIP_ERASE, 17'h00000, 8'h00);
    check("erase_error", {7'h00, rsp_error}, 8'h00);
    run(fcsm_pkg::OP_READ, 17'h00100, 8'h00);
    check("erased", rsp_data, 8'hFF);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    limit = 1'b0;
    busy_reads = 4'h1;
    failures = 0;
    checks_done = 0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    sc_powerup();
    sc_program();
    sc_autosel();
    sc_bypass();
    sc_limit_reset();
    sc_erase();
    stop_test();
  end
endmodule
`default_nettype wire
